// *** ufd_core.sv ***
// Serial transmit and receive data path with FIFOs and RTS/CTS control.
// Operation
// - Send bytes LSB first with full framing.
// - FIFO enable turns holding register into FIFO.
// - Each holding write with room advances the write pointer.
// - Non-FIFO: empty flag set on shift load.
// - Empty flag interrupts only when enabled.
// - Non-FIFO: shifter-empty flag when shifter drains.
// - FIFO mode: empty flag while FIFO empty.
// - FIFO mode: interrupt below transmit trigger.
// - FIFO mode: shifter-empty needs FIFO empty too.
// - Validate start bit at half a bit.
// - Sample bits at centre, report errors.
// - Receive FIFO keeps three tags per byte.
// - Holding read pops, tags follow at once.
// - Data ready per byte or at trigger.
// - Time-out after four characters plus twelve bits.
// - Auto RTS needs feature bit and RTS.
// - RTS rising edge sets flow interrupt flag.
// - RTS goes high at upper threshold.
// - RTS returns low at lower threshold.
// - Keep receiving while RTS is high.
// - Auto CTS high suspends the transmitter.
// - Finish stop bit, resume on CTS low.
// - CTS going high sets flow interrupt flag.
// - Bit time is 16, 8 or 4 samples.
// - Character length is 5 to 8 bits.
`timescale 1ns/1ns
module ufd_core import ufd_pkg::*; #(
	parameter int SAMPLE_DIV = SAMPLE_DIV_DEF,
	parameter int DEPTH      = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [7:0]        regRdata,
	// Serial and handshake pins
	input  wire logic              rxd,
	input  wire logic              ctsN,
	output logic                   txd,
	output logic                   rtsN
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam int DW = $clog2(SAMPLE_DIV + 1);

	logic [7:0] intEnable_q, fifoCtrl_q, lineCtrl_q, modemCtrl_q;
	logic [7:0] enhFeature_q, divFrac_q;
	logic [DW-1:0] divCnt_q;
	logic [2:0] rxS_q, ctsS_q;
	logic rxLine_q, rxLinePrev_q, ctsLine_q, ctsLinePrev_q;
	ufd_tx_state_type txState_q;
	ufd_rx_state_type rxState_q;
	logic [7:0] txShift_q, rxShift_q;
	logic [2:0] txBitIdx_q, rxBitIdx_q;
	logic [4:0] txTick_q, rxTick_q;
	logic txPar_q, txStopIdx_q, rxParAcc_q, rxParErr_q, rxSawOne_q;
	logic [PW-1:0] txWrPtr_q, txRdPtr_q, rxWrPtr_q, rxRdPtr_q;
	logic [CW-1:0] txCount_q, rxCount_q;
	logic overrun_q, rtsOff_q, flowFlag_q;
	logic [9:0] toutCnt_q;
	logic [7:0] txHead;
	logic [RX_ENTRY_W-1:0] rxHead, rxEntry;
	logic sampleTick, fifoEn, txPush, txLoad, txHalt, rxPush, rxPop;
	logic rxFlush, txFlush, rxFull, rxTimeout, rxReady, txEmptyInt;
	logic ctsRise, rtsNext, txBitEnd, rxBitEnd, rxHalfEnd, autoRts;
	logic [CW-1:0] cap, rtsHi, rtsLo;
	logic [4:0] bitLen;
	logic [3:0] wordBits;
	logic [2:0] lastIdx;
	logic [7:0] wordMask, rxData, lsrVal, isrVal;
	logic [9:0] toutLimit;

	// Mode decode shared by both directions.
	assign fifoEn   = fifoCtrl_q[FCR_EN];
	assign bitLen   = divFrac_q[DLD_MODE +: 2] == 2'b01 ? 5'd8 :
	                  divFrac_q[DLD_MODE +: 2] == 2'b10 ? 5'd4 : 5'd16;
	assign wordBits = 4'd5 + {2'b00, lineCtrl_q[1:0]};
	assign lastIdx  = 3'(wordBits - 4'd1);
	assign wordMask = 8'hff >> (4'd8 - wordBits);
	assign cap      = fifoEn ? CW'(DEPTH) : CW'(1);
	assign txPush   = regWr && regAddr == REG_HOLD && txCount_q < cap;
	assign rxPop    = regRd && regAddr == REG_HOLD && rxCount_q != '0;
	assign txFlush  = regWr && regAddr == REG_FCR && regWdata[FCR_TXRST];
	assign rxFlush  = regWr && regAddr == REG_FCR && regWdata[FCR_RXRST];
	assign autoRts  = enhFeature_q[EFR_ARTS];
	assign rtsHi    = CW'(RTS_HI[fifoCtrl_q[FCR_RXTRG +: 2]]);
	assign rtsLo    = CW'(RTS_LO[fifoCtrl_q[FCR_RXTRG +: 2]]);

	// Software registers; the upper enable bits are guarded.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			intEnable_q  <= REG_ZERO;
			fifoCtrl_q   <= REG_ZERO;
			lineCtrl_q   <= LCR_RESET;
			modemCtrl_q  <= REG_ZERO;
			enhFeature_q <= REG_ZERO;
			divFrac_q    <= REG_ZERO;
		end else if (regWr) begin
			unique case (regAddr)
				REG_IER: intEnable_q <= enhFeature_q[EFR_ENH] ? regWdata
				                        : {intEnable_q[7:4], regWdata[3:0]};
				REG_FCR: fifoCtrl_q   <= regWdata & 8'hf9;
				REG_LCR: lineCtrl_q   <= regWdata;
				REG_MCR: modemCtrl_q  <= regWdata;
				REG_EFR: enhFeature_q <= regWdata;
				REG_DLD: divFrac_q    <= regWdata;
				default: ;
			endcase
		end
	end

	// Sampling clock; the fractional baud divider is outside this block.
	assign sampleTick = divCnt_q == DW'(SAMPLE_DIV - 1);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_q <= '0;
		end else begin
			divCnt_q <= sampleTick ? '0 : divCnt_q + 1'b1;
		end
	end

	// Pin synchronisers; a level counts once the last two stages agree.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxS_q         <= 3'h7;
			ctsS_q        <= 3'h7;
			rxLine_q      <= 1'b1;
			rxLinePrev_q  <= 1'b1;
			ctsLine_q     <= 1'b1;
			ctsLinePrev_q <= 1'b1;
		end else begin
			rxS_q         <= {rxS_q[1:0], rxd};
			ctsS_q        <= {ctsS_q[1:0], ctsN};
			rxLinePrev_q  <= rxLine_q;
			ctsLinePrev_q <= ctsLine_q;
			if (rxS_q[1] == rxS_q[2]) begin
				rxLine_q <= rxS_q[2];
			end
			if (ctsS_q[1] == ctsS_q[2]) begin
				ctsLine_q <= ctsS_q[2];
			end
		end
	end

	// Transmit FIFO storage.
	ufd_mem #(.WIDTH(8), .DEPTH(DEPTH)) txMem (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.wrEn    (txPush),
		.wrAddr  (txWrPtr_q),
		.wrData  (regWdata),
		.rdAddr  (txLoad ? txRdPtr_q + 1'b1 : txRdPtr_q),
		.rdData  (txHead)
	);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			txWrPtr_q <= '0;
			txRdPtr_q <= '0;
			txCount_q <= '0;
		end else if (txFlush) begin
			txWrPtr_q <= '0;
			txRdPtr_q <= '0;
			txCount_q <= '0;
		end else begin
			if (txPush) begin
				txWrPtr_q <= txWrPtr_q + 1'b1;
			end
			if (txLoad) begin
				txRdPtr_q <= txRdPtr_q + 1'b1;
			end
			txCount_q <= txCount_q + CW'(txPush) - CW'(txLoad);
		end
	end

	assign txHalt   = enhFeature_q[EFR_ACTS] && ctsLine_q;
	assign txLoad   = txState_q == TX_IDLE && txCount_q != '0 && !txHalt;
	assign txBitEnd = sampleTick && txTick_q == bitLen - 5'd1;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			txState_q   <= TX_IDLE;
			txd         <= 1'b1;
			txShift_q   <= '0;
			txBitIdx_q  <= '0;
			txTick_q    <= '0;
			txPar_q     <= 1'b0;
			txStopIdx_q <= 1'b0;
		end else begin
			if (txState_q != TX_IDLE && sampleTick) begin
				txTick_q <= txBitEnd ? 5'd0 : txTick_q + 5'd1;
			end
			unique case (txState_q)
				TX_IDLE: begin
					txd <= !txLoad;
					if (txLoad) begin
						txShift_q <= txHead & wordMask;
						txPar_q   <= ^(txHead & wordMask) ^
						             !lineCtrl_q[LCR_EVEN];
						txTick_q  <= '0;
						txState_q <= TX_START;
					end
				end
				TX_START: if (txBitEnd) begin
					txd        <= txShift_q[0];
					txBitIdx_q <= '0;
					txState_q  <= TX_DATA;
				end
				TX_DATA: if (txBitEnd) begin
					txShift_q  <= txShift_q >> 1;
					txBitIdx_q <= txBitIdx_q + 3'd1;
					if (txBitIdx_q != lastIdx) begin
						txd <= txShift_q[1];
					end else if (lineCtrl_q[LCR_PAR]) begin
						txd       <= txPar_q;
						txState_q <= TX_PAR;
					end else begin
						txd         <= 1'b1;
						txStopIdx_q <= 1'b0;
						txState_q   <= TX_STOP;
					end
				end
				TX_PAR: if (txBitEnd) begin
					txd         <= 1'b1;
					txStopIdx_q <= 1'b0;
					txState_q   <= TX_STOP;
				end
				TX_STOP: if (txBitEnd) begin
					txStopIdx_q <= 1'b1;
					if (!lineCtrl_q[LCR_STOP] || txStopIdx_q) begin
						txState_q <= TX_IDLE;
					end
				end
				default: txState_q <= TX_IDLE;
			endcase
		end
	end

	// Receive side: the start bit is judged at half a bit time.
	assign rxHalfEnd = sampleTick && rxTick_q == (bitLen >> 1) - 5'd1;
	assign rxBitEnd  = sampleTick && rxTick_q == bitLen - 5'd1;
	assign rxData    = rxShift_q >> (4'd8 - wordBits);
	assign rxPush    = rxState_q == RX_STOP && rxBitEnd;
	assign rxFull    = rxCount_q >= cap;
	assign rxEntry   = {!rxSawOne_q && !rxLine_q, !rxLine_q, rxParErr_q,
	                    rxData};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxState_q  <= RX_IDLE;
			rxShift_q  <= '0;
			rxBitIdx_q <= '0;
			rxTick_q   <= '0;
			rxParAcc_q <= 1'b0;
			rxParErr_q <= 1'b0;
			rxSawOne_q <= 1'b0;
		end else begin
			if (rxState_q != RX_IDLE && sampleTick) begin
				rxTick_q <= rxTick_q + 5'd1;
			end
			unique case (rxState_q)
				RX_IDLE: if (rxLinePrev_q && !rxLine_q) begin
					rxTick_q  <= '0;
					rxState_q <= RX_START;
				end
				RX_START: if (rxHalfEnd) begin
					rxTick_q   <= '0;
					rxBitIdx_q <= '0;
					rxParAcc_q <= 1'b0;
					rxParErr_q <= 1'b0;
					rxSawOne_q <= 1'b0;
					rxState_q  <= rxLine_q ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rxBitEnd) begin
					rxTick_q   <= '0;
					rxShift_q  <= {rxLine_q, rxShift_q[7:1]};
					rxParAcc_q <= rxParAcc_q ^ rxLine_q;
					rxSawOne_q <= rxSawOne_q | rxLine_q;
					rxBitIdx_q <= rxBitIdx_q + 3'd1;
					if (rxBitIdx_q == lastIdx) begin
						rxState_q <= lineCtrl_q[LCR_PAR] ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (rxBitEnd) begin
					rxTick_q   <= '0;
					rxParErr_q <= (rxParAcc_q ^ rxLine_q) ==
					              lineCtrl_q[LCR_EVEN];
					rxSawOne_q <= rxSawOne_q | rxLine_q;
					rxState_q  <= RX_STOP;
				end
				RX_STOP: if (rxBitEnd) begin
					rxState_q <= RX_IDLE;
				end
				default: rxState_q <= RX_IDLE;
			endcase
		end
	end

	ufd_mem #(.WIDTH(RX_ENTRY_W), .DEPTH(DEPTH)) rxMem (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.wrEn    (rxPush && !rxFull),
		.wrAddr  (rxWrPtr_q),
		.wrData  (rxEntry),
		.rdAddr  (rxPop ? rxRdPtr_q + 1'b1 : rxRdPtr_q),
		.rdData  (rxHead)
	);

	// Storing goes on regardless of RTS
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxWrPtr_q <= '0;
			rxRdPtr_q <= '0;
			rxCount_q <= '0;
		end else if (rxFlush) begin
			rxWrPtr_q <= '0;
			rxRdPtr_q <= '0;
			rxCount_q <= '0;
		end else begin
			if (rxPush && !rxFull) begin
				rxWrPtr_q <= rxWrPtr_q + 1'b1;
			end
			if (rxPop) begin
				rxRdPtr_q <= rxRdPtr_q + 1'b1;
			end
			rxCount_q <= rxCount_q + CW'(rxPush && !rxFull) - CW'(rxPop);
		end
	end

	// Idle time-out, counted in sample clocks
	assign toutLimit = 10'((TOUT_CHARS * int'(wordBits) + TOUT_BITS) *
	                       int'(bitLen));
	assign rxTimeout = rxCount_q != '0 && toutCnt_q >= toutLimit;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			toutCnt_q <= '0;
		end else if (rxPush || rxPop || rxCount_q == '0) begin
			toutCnt_q <= '0;
		end else if (sampleTick && toutCnt_q < toutLimit) begin
			toutCnt_q <= toutCnt_q + 10'd1;
		end
	end

	// Overrun is sticky; a new overrun wins over the status read.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			overrun_q <= 1'b0;
		end else if (rxPush && rxFull) begin
			overrun_q <= 1'b1;
		end else if (regRd && regAddr == REG_LSR) begin
			overrun_q <= 1'b0;
		end
	end

	// RTS only once software asserts it
	assign rtsNext = !modemCtrl_q[MCR_RTS] || rtsOff_q;
	assign ctsRise = !ctsLinePrev_q && ctsLine_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rtsOff_q   <= 1'b0;
			rtsN       <= 1'b1;
			flowFlag_q <= 1'b0;
		end else begin
			rtsN <= rtsNext;
			if (!autoRts) begin
				rtsOff_q <= 1'b0;
			end else if (rxCount_q >= rtsHi) begin
				rtsOff_q <= 1'b1;
			end else if (rxCount_q <= rtsLo) begin
				rtsOff_q <= 1'b0;
			end
			if ((intEnable_q[IER_RTS] && !rtsN && rtsNext) ||
			    (intEnable_q[IER_CTS] && ctsRise)) begin
				flowFlag_q <= 1'b1;
			end else if (regRd && regAddr == REG_ISR) begin
				flowFlag_q <= 1'b0;
			end
		end
	end

	// Data ready per byte or at trigger
	assign rxReady = fifoEn ?
	                 rxCount_q >= CW'(RX_TRIG[fifoCtrl_q[FCR_RXTRG +: 2]]) :
	                 rxCount_q != '0;
	assign txEmptyInt = fifoEn ?
	                 txCount_q < CW'(TX_TRIG[fifoCtrl_q[FCR_TXTRG +: 2]]) :
	                 txCount_q == '0;

	always_comb begin
		lsrVal    = '0;
		lsrVal[0] = rxCount_q != '0;
		lsrVal[1] = overrun_q;
		// Tags of the byte on top
		lsrVal[4:2] = rxCount_q != '0 ? rxHead[TAG_BRK:TAG_PAR] : 3'b000;
		lsrVal[5] = txCount_q == '0;
		lsrVal[6] = txCount_q == '0 && txState_q == TX_IDLE;
		if (intEnable_q[IER_RX] && rxTimeout) begin
			isrVal = ISR_TOUT;
		end else if (intEnable_q[IER_RX] && rxReady) begin
			isrVal = ISR_RX;
		end else if (intEnable_q[IER_TX] && txEmptyInt) begin
			isrVal = ISR_TX;
		end else if (flowFlag_q) begin
			isrVal = ISR_FLOW;
		end else begin
			isrVal = ISR_NONE;
		end
	end

	// Read data stand for one cycle only, zero otherwise.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= '0;
		end else if (!regRd) begin
			regRdata <= '0;
		end else begin
			unique case (regAddr)
				REG_HOLD: regRdata <= rxHead[7:0];
				REG_IER:  regRdata <= intEnable_q;
				REG_ISR:  regRdata <= isrVal;
				REG_FCR:  regRdata <= fifoCtrl_q;
				REG_LCR:  regRdata <= lineCtrl_q;
				REG_MCR:  regRdata <= modemCtrl_q;
				REG_LSR:  regRdata <= lsrVal;
				REG_EFR:  regRdata <= enhFeature_q;
				REG_DLD:  regRdata <= divFrac_q;
				default:  regRdata <= '0;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	txIdleHigh_a: assert property (
		txState_q == TX_IDLE |-> txd)
		else $error("transmit line not high while idle");
	startBit_a: assert property (
		txLoad |=> txState_q == TX_START && !txd)
		else $error("no start bit after load");
	ctsHold_a: assert property (
		txHalt && txState_q == TX_IDLE |=> txState_q == TX_IDLE)
		else $error("character started while CTS high");
	txPtrStep_a: assert property (
		txPush && !txFlush |=> txWrPtr_q == $past(txWrPtr_q) + 1'b1)
		else $error("write pointer did not advance");
	thrEmpty_a: assert property (
		txLoad && txCount_q == CW'(1) && !txPush && !txFlush
		|=> lsrVal[5] && !lsrVal[6])
		else $error("empty flags wrong after shift load");
	falseStart_a: assert property (
		rxState_q == RX_START && rxHalfEnd && rxLine_q
		|=> rxState_q == RX_IDLE)
		else $error("false start bit accepted");
	rxPop_a: assert property (
		rxPop && !rxFlush |=> rxRdPtr_q == $past(rxRdPtr_q) + 1'b1)
		else $error("read pointer did not advance");
	rtsHigh_a: assert property (
		$rose(rtsOff_q) |=> rtsN)
		else $error("RTS not raised at upper threshold");
	rtsLow_a: assert property (
		autoRts && modemCtrl_q[MCR_RTS] && rxCount_q <= rtsLo && !regWr
		##1 !regWr |=> !rtsN)
		else $error("RTS not lowered at lower threshold");
	ctsFlag_a: assert property (
		ctsRise && intEnable_q[IER_CTS] |=> flowFlag_q)
		else $error("CTS rise did not set flow flag");

	rxChar_c: cover property (rxPush && !rxFull);
	ctsPause_c: cover property (txHalt && txState_q == TX_STOP);
	rtsOff_c: cover property ($rose(rtsN) && autoRts);
	timeout_c: cover property (rxTimeout);

endmodule

// *** ufd_pkg.sv ***
// Shared constants and types for the serial data path block.
package ufd_pkg;

	// Register port width and register offsets.
	localparam int         ADDR_W   = 4;
	localparam logic [3:0] REG_HOLD = 4'h0;
	localparam logic [3:0] REG_IER  = 4'h1;
	localparam logic [3:0] REG_ISR  = 4'h2;
	localparam logic [3:0] REG_FCR  = 4'h3;
	localparam logic [3:0] REG_LCR  = 4'h4;
	localparam logic [3:0] REG_MCR  = 4'h5;
	localparam logic [3:0] REG_LSR  = 4'h6;
	localparam logic [3:0] REG_EFR  = 4'h7;
	localparam logic [3:0] REG_DLD  = 4'h8;

	// Field positions.
	localparam int IER_RX    = 0;
	localparam int IER_TX    = 1;
	localparam int IER_RTS   = 6;
	localparam int IER_CTS   = 7;
	localparam int FCR_EN    = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_TXTRG = 4;
	localparam int FCR_RXTRG = 6;
	localparam int LCR_STOP  = 2;
	localparam int LCR_PAR   = 3;
	localparam int LCR_EVEN  = 4;
	localparam int MCR_RTS   = 1;
	localparam int EFR_ENH   = 4;
	localparam int EFR_ARTS  = 6;
	localparam int EFR_ACTS  = 7;
	localparam int DLD_MODE  = 4;
	localparam int TAG_PAR   = 8;
	localparam int TAG_FRM   = 9;
	localparam int TAG_BRK   = 10;

	// Reset values.
	localparam logic [7:0] LCR_RESET = 8'h03;
	localparam logic [7:0] REG_ZERO  = 8'h00;

	// Interrupt source codes.
	localparam logic [7:0] ISR_NONE = 8'h01;
	localparam logic [7:0] ISR_TX   = 8'h02;
	localparam logic [7:0] ISR_RX   = 8'h04;
	localparam logic [7:0] ISR_TOUT = 8'h0c;
	localparam logic [7:0] ISR_FLOW = 8'h20;

	// Sizes, sample clock and time-out figures.
	localparam int FIFO_DEPTH     = 32;
	localparam int RX_ENTRY_W     = 11;
	localparam int SAMPLE_DIV_DEF = 16;
	localparam int TOUT_CHARS     = 4;
	localparam int TOUT_BITS      = 12;

	// Trigger and hysteresis tables, indexed by the trigger select.
	localparam int RX_TRIG [4] = '{8, 16, 24, 28};
	localparam int TX_TRIG [4] = '{8, 16, 24, 28};
	localparam int RTS_HI  [4] = '{16, 24, 28, 28};
	localparam int RTS_LO  [4] = '{0, 8, 16, 24};

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} ufd_tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} ufd_rx_state_type;

endpackage

// *** ufd_mem.sv ***
// Small FIFO storage with a registered, write-through read port.
`timescale 1ns/1ns
module ufd_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	// Write port
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	// Read port
	input  wire logic [AW-1:0]    rdAddr,
	output logic      [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	// A write into the entry being read shows at once, so an empty
	// FIFO that takes a byte presents it on the very next cycle.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= '0;
		end else if (wrEn && wrAddr == rdAddr) begin
			rdData <= wrData;
		end else begin
			rdData <= store[rdAddr];
		end
	end

endmodule

// *** ufd_remote.sv ***
// Remote serial partner with request-to-send handshake.
`timescale 1ns/1ns
module ufd_remote #(
	parameter int BITCYC = 16
) (
	// Clock
	input  wire logic ref_clk,
	// Device pins
	input  wire logic txd,
	input  wire logic rtsN,
	input  wire logic holdTx,
	output logic      rxd,
	output logic      ctsN
);
	logic [7:0] gotQ [$];
	logic [7:0] shiftV;
	// The bench shortens the bit time when it moves to 8 samples per bit.
	int         bitCyc = BITCYC;

	assign ctsN = holdTx;
	initial rxd = 1'b1;

	task automatic send(input logic [7:0] d, input logic stopBit);
		logic [9:0] frame;
		frame = {stopBit, d, 1'b0};
		while (rtsN) @(posedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			rxd <= frame[i];
			repeat (bitCyc - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		rxd <= 1'b1;
	endtask

	// The line idles high, so a falling edge always marks a start bit.
	always begin
		@(negedge txd);
		repeat (bitCyc / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bitCyc) @(posedge ref_clk);
			shiftV[i] = txd;
		end
		repeat (bitCyc) @(posedge ref_clk);
		gotQ.push_back(shiftV);
	end
endmodule

// *** uart_fifo_datapath_rts_cts_bench.sv ***
// Register-level bench for the serial data path block.
`timescale 1ns/1ns
module uart_fifo_datapath_rts_cts_bench import ufd_pkg::*;;
	logic              ref_clk;
	logic              arst_n;
	logic [ADDR_W-1:0] regAddr;
	logic [7:0]        regWdata;
	logic              regWr;
	logic              regRd;
	logic [7:0]        regRdata;
	logic              rxd;
	logic              ctsN;
	logic              txd;
	logic              rtsN;
	logic              holdTx;
	int                errCount;
	int                samplesChecked;

	ufd_core #(.SAMPLE_DIV(1)) u_ufd_core (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.regAddr (regAddr),
		.regWdata(regWdata),
		.regWr   (regWr),
		.regRd   (regRd),
		.regRdata(regRdata),
		.rxd     (rxd),
		.ctsN    (ctsN),
		.txd     (txd),
		.rtsN    (rtsN)
	);

	ufd_remote #(.BITCYC(16)) u_ufd_remote (
		.ref_clk(ref_clk),
		.txd    (txd),
		.rtsN   (rtsN),
		.holdTx (holdTx),
		.rxd    (rxd),
		.ctsN   (ctsN)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
		@(posedge ref_clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		chk(n, e, regRdata);
	endtask

	task automatic waitGot(input int n);
		repeat (4000) if (u_ufd_remote.gotQ.size() < n) @(posedge ref_clk);
	endtask

	task automatic completeRun();
		$display("checks %0d mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk);
		errCount++;
		completeRun();
	end

	initial begin
		arst_n = 1'b0;
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		holdTx = 1'b0;
		errCount = 0;
		samplesChecked = 0;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(REG_LCR, 8'h03, "lcr reset");
		rd(REG_LSR, 8'h60, "lsr reset");
		rd(REG_ISR, 8'h01, "isr reset");
		rd(4'hf, 8'h00, "unmapped");
		$display("reset test done");

		wr(REG_IER, 8'h02);
		rd(REG_ISR, 8'h02, "isr tx empty");
		wr(REG_HOLD, 8'ha5);
		rd(REG_LSR, 8'h20, "lsr loaded");
		waitGot(1);
		chk("tx byte", 8'ha5, u_ufd_remote.gotQ[0]);
		repeat (20) @(posedge ref_clk);
		rd(REG_LSR, 8'h60, "lsr drained");
		wr(REG_IER, 8'h00);
		$display("plain transmit test done");

		wr(REG_FCR, 8'h01);
		for (int i = 1; i < 4; i++) wr(REG_HOLD, 8'(i * 8'h11));
		rd(REG_LSR, 8'h00, "lsr fifo busy");
		waitGot(4);
		for (int i = 1; i < 4; i++)
			chk("fifo byte", 8'(i * 8'h11), u_ufd_remote.gotQ[i]);
		repeat (20) @(posedge ref_clk);
		rd(REG_LSR, 8'h60, "lsr fifo idle");
		$display("fifo transmit test done");

		wr(REG_MCR, 8'h02);
		// The pin is registered, so it follows one clock after the write.
		@(posedge ref_clk);
		#1;
		chk("rts on", 8'h00, {7'h0, rtsN});
		wr(REG_IER, 8'h01);
		u_ufd_remote.send(8'h3c, 1'b1);
		rd(REG_LSR, 8'h61, "lsr rx ok");
		rd(REG_ISR, 8'h01, "isr below trig");
		repeat (720) @(posedge ref_clk);
		rd(REG_ISR, 8'h0c, "isr timeout");
		rd(REG_HOLD, 8'h3c, "rx byte");
		rd(REG_ISR, 8'h01, "isr after pop");
		u_ufd_remote.send(8'h55, 1'b0);
		rd(REG_LSR, 8'h69, "lsr framing");
		rd(REG_HOLD, 8'h55, "rx bad byte");
		rd(REG_LSR, 8'h60, "lsr empty");
		$display("receive test done");

		wr(REG_EFR, 8'h50);
		wr(REG_IER, 8'h40);
		for (int i = 0; i < 16; i++) u_ufd_remote.send(8'h80 + 8'(i), 1'b1);
		repeat (4) @(posedge ref_clk);
		chk("rts off", 8'h01, {7'h0, rtsN});
		rd(REG_ISR, 8'h20, "isr rts");
		wr(REG_IER, 8'h41);
		rd(REG_ISR, 8'h04, "isr trig");
		for (int i = 0; i < 16; i++) begin
			rd(REG_HOLD, 8'h80 + 8'(i), "rx fifo");
			if (i == 14) chk("rts held", 8'h01, {7'h0, rtsN});
		end
		repeat (3) @(posedge ref_clk);
		chk("rts back", 8'h00, {7'h0, rtsN});
		$display("auto rts test done");

		wr(REG_EFR, 8'h90);
		wr(REG_IER, 8'h80);
		holdTx <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rd(REG_ISR, 8'h20, "isr cts");
		rd(REG_ISR, 8'h01, "isr cleared");
		wr(REG_IER, 8'h82);
		rd(REG_ISR, 8'h02, "isr tx below");
		for (int i = 0; i < 8; i++) wr(REG_HOLD, 8'h5a + 8'(i));
		rd(REG_ISR, 8'h01, "isr tx at trig");
		repeat (400) @(posedge ref_clk);
		chk("tx held", 8'h04, 8'(u_ufd_remote.gotQ.size()));
		holdTx <= 1'b0;
		// Stop again in mid-character: that character must still finish.
		@(negedge txd);
		holdTx <= 1'b1;
		repeat (400) @(posedge ref_clk);
		chk("tx paused", 8'h05, 8'(u_ufd_remote.gotQ.size()));
		holdTx <= 1'b0;
		waitGot(12);
		for (int i = 0; i < 8; i++)
			chk("tx resume", 8'h5a + 8'(i), u_ufd_remote.gotQ[4 + i]);
		$display("auto cts test done");

		repeat (20) @(posedge ref_clk);
		wr(REG_EFR, 8'h00);
		wr(REG_LCR, 8'h1a);
		wr(REG_DLD, 8'h10);
		u_ufd_remote.bitCyc = 8;
		// The partner takes the parity bit as its eighth data bit.
		wr(REG_HOLD, 8'h43);
		waitGot(13);
		chk("tx parity", 8'hc3, u_ufd_remote.gotQ[12]);
		u_ufd_remote.send(8'hc3, 1'b1);
		rd(REG_LSR, 8'h61, "lsr 8x ok");
		rd(REG_HOLD, 8'h43, "rx 7 bit");
		u_ufd_remote.send(8'h43, 1'b1);
		rd(REG_LSR, 8'h65, "lsr parity");
		rd(REG_HOLD, 8'h43, "rx bad parity");
		$display("mode test done");
		completeRun();
	end
endmodule
